// File: design/csrc_consts.vh
`ifndef CSRC_CONSTS_VH
`define CSRC_CONSTS_VH

// Register indices and APB byte addresses (index times four).
`define CSRC_IDX_CACHE      8'h21
`define CSRC_IDX_SHADOW     8'h22
`define CSRC_IDX_SEGMENT    8'h23
`define CSRC_IDX_ROMWR      8'h26
`define CSRC_ADDR_CACHE     12'h084
`define CSRC_ADDR_SHADOW    12'h088
`define CSRC_ADDR_SEGMENT   12'h08c
`define CSRC_ADDR_ROMWR     12'h098

// Reset values.
`define CSRC_RST_CACHE      8'h00
`define CSRC_RST_SHADOW     8'he4
`define CSRC_RST_SEGMENT    8'h00
`define CSRC_RST_ROMWR      8'h00

// Field positions in cache_control.
`define CSRC_BIT_SWAP       7
`define CSRC_BIT_DBG        6
`define CSRC_BIT_PAR_OFF    5
`define CSRC_BIT_L2_EN      4
`define CSRC_BIT_SIZE_HI    3
`define CSRC_BIT_SIZE_LO    2
`define CSRC_BIT_WR_FAST    1
`define CSRC_BIT_RD_FAST    0

// Field positions in shadow_refresh_control.
`define CSRC_BIT_TOP_ROM    7
`define CSRC_BIT_D_WP       4
`define CSRC_BIT_E_WP       3
`define CSRC_BIT_CONV_REF   2
`define CSRC_BIT_A20_HIGH   1
`define CSRC_BIT_SLOW_REF   0

// Field position in the flash write select register.
`define CSRC_BIT_ROM_WR     7

// Segment codes of address bits 31:16.
`define CSRC_SEG_D          16'h000d
`define CSRC_SEG_E          16'h000e
`define CSRC_SEG_F          16'h000f

// Leadoff lengths in clocks.
`define CSRC_LEAD_SLOW      2'h3
`define CSRC_LEAD_FAST      2'h2

// Slow refresh passes one tick in four.
`define CSRC_SLOW_LAST      2'h3

`endif

// File: design/csrc_top.v
// Register access over APB is this design's own decision.
`timescale 1ns/10ps
`include "csrc_consts.vh"

module csrc_top #(
    parameter AW = 12
) (
    input  wire          sys_clk,
    input  wire          rst_n,
    input  wire          psel,
    input  wire          penable,
    input  wire          pwrite,
    input  wire [AW-1:0] paddr,
    input  wire [31:0]   pwdata,
    output wire [31:0]   prdata,
    output wire          pready,
    output wire          pslverr,
    input  wire          mem_start,
    input  wire          mem_write,
    input  wire [31:0]   mem_addr,
    output wire          mem_claim,
    output wire          rom_select_n,
    output wire          dram_select,
    output wire          dram_write_en,
    output wire          write_drop,
    output wire          isa_forward,
    input  wire          refresh_tick,
    input  wire          refresh_busy,
    output wire          refresh_req,
    output wire          hold_req,
    input  wire          kbd_a20_gate,
    output wire          addr20_mask_n,
    output wire          byte_swap_en,
    output wire          parity_check_en,
    output wire          l2_enable,
    output wire [3:0]    l2_size_sel,
    output wire [1:0]    l2_wr_leadoff,
    output wire [1:0]    l2_rd_leadoff
);

    reg  [7:0]  cache_ctl_ff;
    reg  [7:0]  shadow_ctl_ff;
    reg  [7:0]  segment_ff;
    reg         rom_wr_ff;
    reg         pready_ff;
    reg         pslverr_ff;
    reg  [31:0] prdata_ff;
    reg         claim_ff;
    reg         rom_sel_n_ff;
    reg         dram_sel_ff;
    reg         dram_we_ff;
    reg         drop_ff;
    reg         isa_ff;
    reg  [1:0]  slow_cnt_ff;
    reg         refresh_req_ff;
    reg         hold_ff;
    reg         a20_ff;
    reg         swap_ff;
    reg         parity_ff;
    reg         l2_en_ff;
    reg  [3:0]  size_ff;
    reg  [1:0]  wr_lead_ff;
    reg  [1:0]  rd_lead_ff;

    wire        access;
    wire        wr_fire;
    wire [3:0]  reg_sel;
    reg  [7:0]  rd_byte;
    wire        rd_hit;
    wire [15:0] seg;
    wire [1:0]  blk;
    wire        d_shadow;
    wire        e_shadow;

    reg         nxt_claim;
    reg         nxt_rom_sel_n;
    reg         nxt_dram_sel;
    reg         nxt_dram_we;
    reg         nxt_drop;
    reg         nxt_isa;
    reg  [1:0]  nxt_slow_cnt;
    reg         nxt_refresh_req;

    // One-hot decode of a two-bit field; used for blocks and cache size.
    function [3:0] dec4;
        input [1:0] sel;
        begin
            dec4 = 4'h1 << sel;
        end
    endfunction

    // Leadoff length in clocks for one cache timing bit.
    function [1:0] lead_clocks;
        input fast;
        begin
            lead_clocks = fast ? `CSRC_LEAD_FAST : `CSRC_LEAD_SLOW;
        end
    endfunction

    // Address decode shared by the read mux, the error flag and the write strobes.
    // It is one-hot, so a stray offset can never open two registers at once.
    function [3:0] reg_dec;
        input [AW-1:0] addr;
        begin
            case (addr)
                `CSRC_ADDR_CACHE: begin
                    reg_dec = 4'h1;
                end
                `CSRC_ADDR_SHADOW: begin
                    reg_dec = 4'h2;
                end
                `CSRC_ADDR_SEGMENT: begin
                    reg_dec = 4'h4;
                end
                `CSRC_ADDR_ROMWR: begin
                    reg_dec = 4'h8;
                end
                default: begin
                    reg_dec = 4'h0;
                end
            endcase
        end
    endfunction

    // Steering of one shadowed segment: {dram_select, dram_write_en, write_drop, isa}.
    function [3:0] seg_steer;
        input shadow_on;
        input protect;
        input is_write;
        begin
            if (!shadow_on) begin
                seg_steer = 4'h1;
            end else if (is_write & protect) begin
                seg_steer = 4'h2;
            end else begin
                seg_steer = {1'b1, is_write, 2'b00};
            end
        end
    endfunction

    // Reset image of the flash write select register; only its top bit is stored.
    localparam [7:0] ROMWR_RST = `CSRC_RST_ROMWR;

    // The slave inserts one wait cycle so read data comes from a flop.
    assign access  = psel & penable;
    assign wr_fire = access & pready_ff & pwrite & ~pslverr_ff;

    assign reg_sel = reg_dec(paddr);
    assign rd_hit  = |reg_sel;

    // Unmapped offsets read as zero and raise pslverr in the same cycle.
    always @* begin
        case (reg_sel)
            4'h1: begin
                rd_byte = cache_ctl_ff;
            end
            4'h2: begin
                rd_byte = shadow_ctl_ff;
            end
            4'h4: begin
                rd_byte = segment_ff;
            end
            4'h8: begin
                rd_byte = {rom_wr_ff, 7'h00};
            end
            default: begin
                rd_byte = 8'h00;
            end
        endcase
    end

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h0000_0000;
        end else begin
            // The error flag rises with pready, so a refused write never reaches a store.
            pready_ff  <= access & ~pready_ff;
            pslverr_ff <= access & ~pready_ff & ~rd_hit;
            if (access & ~pready_ff) begin
                prdata_ff <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
            end
        end
    end

    // Reserved debug bits are stored as written; software keeps them at default.
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cache_ctl_ff  <= `CSRC_RST_CACHE;
            shadow_ctl_ff <= `CSRC_RST_SHADOW;
            segment_ff    <= `CSRC_RST_SEGMENT;
            rom_wr_ff     <= ROMWR_RST[`CSRC_BIT_ROM_WR];
        end else if (wr_fire) begin
            if (reg_sel[0]) begin
                cache_ctl_ff <= pwdata[7:0];
            end
            if (reg_sel[1]) begin
                shadow_ctl_ff <= pwdata[7:0];
            end
            if (reg_sel[2]) begin
                segment_ff <= pwdata[7:0];
            end
            if (reg_sel[3]) begin
                rom_wr_ff <= pwdata[`CSRC_BIT_ROM_WR];
            end
        end
    end

    // Static configuration outputs, registered one cycle after the store.
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            swap_ff    <= 1'b0;
            parity_ff  <= 1'b1;
            l2_en_ff   <= 1'b0;
            size_ff    <= 4'h1;
            wr_lead_ff <= `CSRC_LEAD_SLOW;
            rd_lead_ff <= `CSRC_LEAD_SLOW;
            a20_ff     <= 1'b0;
        end else begin
            swap_ff   <= cache_ctl_ff[`CSRC_BIT_SWAP];
            parity_ff <= ~cache_ctl_ff[`CSRC_BIT_PAR_OFF];
            l2_en_ff  <= cache_ctl_ff[`CSRC_BIT_L2_EN];
            size_ff   <= dec4(cache_ctl_ff[`CSRC_BIT_SIZE_HI:`CSRC_BIT_SIZE_LO]);
            wr_lead_ff <= lead_clocks(cache_ctl_ff[`CSRC_BIT_WR_FAST]);
            rd_lead_ff <= lead_clocks(cache_ctl_ff[`CSRC_BIT_RD_FAST]);
            // The keyboard gate is sampled here, so the pin lags it by one clock.
            a20_ff <= shadow_ctl_ff[`CSRC_BIT_A20_HIGH] | kbd_a20_gate;
        end
    end

    // Memory cycle steering for the D, E and F segments.
    assign seg = mem_addr[31:16];
    assign blk = mem_addr[15:14];
    assign d_shadow = |(segment_ff[3:0] & dec4(blk));
    assign e_shadow = |(segment_ff[7:4] & dec4(blk));

    always @* begin
        nxt_claim     = 1'b0;
        nxt_rom_sel_n = 1'b1;
        nxt_dram_sel  = 1'b0;
        nxt_dram_we   = 1'b0;
        nxt_drop      = 1'b0;
        nxt_isa       = 1'b0;
        if (mem_start) begin
            case (seg)
                `CSRC_SEG_F: begin
                    nxt_claim = 1'b1;
                    if (shadow_ctl_ff[`CSRC_BIT_TOP_ROM]) begin
                        // Flash parts need the ROM select on writes too, when enabled.
                        nxt_rom_sel_n = mem_write ? ~rom_wr_ff : 1'b0;
                        nxt_dram_sel  = mem_write;
                        nxt_dram_we   = mem_write;
                    end else begin
                        nxt_dram_sel = ~mem_write;
                        nxt_drop     = mem_write;
                    end
                end
                `CSRC_SEG_E: begin
                    nxt_claim = 1'b1;
                    {nxt_dram_sel, nxt_dram_we, nxt_drop, nxt_isa} =
                        seg_steer(e_shadow, shadow_ctl_ff[`CSRC_BIT_E_WP], mem_write);
                end
                `CSRC_SEG_D: begin
                    nxt_claim = 1'b1;
                    {nxt_dram_sel, nxt_dram_we, nxt_drop, nxt_isa} =
                        seg_steer(d_shadow, shadow_ctl_ff[`CSRC_BIT_D_WP], mem_write);
                end
                default: begin
                    nxt_claim = 1'b0;
                end
            endcase
        end
    end

    // Steering outputs are one-cycle pulses, one clock after mem_start.
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            claim_ff     <= 1'b0;
            rom_sel_n_ff <= 1'b1;
            dram_sel_ff  <= 1'b0;
            dram_we_ff   <= 1'b0;
            drop_ff      <= 1'b0;
            isa_ff       <= 1'b0;
        end else begin
            claim_ff     <= nxt_claim;
            rom_sel_n_ff <= nxt_rom_sel_n;
            dram_sel_ff  <= nxt_dram_sel;
            dram_we_ff   <= nxt_dram_we;
            drop_ff      <= nxt_drop;
            isa_ff       <= nxt_isa;
        end
    end

    // Refresh pacing: in slow mode only every fourth timer tick is passed on.
    always @* begin
        // A normal-rate tick restarts the count, so slow mode begins a fresh quarter.
        nxt_slow_cnt    = slow_cnt_ff;
        nxt_refresh_req = 1'b0;
        if (refresh_tick) begin
            if (!shadow_ctl_ff[`CSRC_BIT_SLOW_REF]) begin
                nxt_slow_cnt    = 2'h0;
                nxt_refresh_req = 1'b1;
            end else if (slow_cnt_ff == `CSRC_SLOW_LAST) begin
                nxt_slow_cnt    = 2'h0;
                nxt_refresh_req = 1'b1;
            end else begin
                nxt_slow_cnt = slow_cnt_ff + 2'h1;
            end
        end
    end

    // Hold follows the refresh engine's busy level while the conventional refresh bit is set, so a long refresh keeps the CPU off.
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            slow_cnt_ff    <= 2'h0;
            refresh_req_ff <= 1'b0;
            hold_ff        <= 1'b0;
        end else begin
            slow_cnt_ff    <= nxt_slow_cnt;
            refresh_req_ff <= nxt_refresh_req;
            hold_ff <= shadow_ctl_ff[`CSRC_BIT_CONV_REF] & refresh_busy;
        end
    end

    assign prdata          = prdata_ff;
    assign pready          = pready_ff;
    assign pslverr         = pslverr_ff;
    assign mem_claim       = claim_ff;
    assign rom_select_n    = rom_sel_n_ff;
    assign dram_select     = dram_sel_ff;
    assign dram_write_en   = dram_we_ff;
    assign write_drop      = drop_ff;
    assign isa_forward     = isa_ff;
    assign refresh_req     = refresh_req_ff;
    assign hold_req        = hold_ff;
    assign addr20_mask_n   = a20_ff;
    assign byte_swap_en    = swap_ff;
    assign parity_check_en = parity_ff;
    assign l2_enable       = l2_en_ff;
    assign l2_size_sel     = size_ff;
    assign l2_wr_leadoff   = wr_lead_ff;
    assign l2_rd_leadoff   = rd_lead_ff;

endmodule

// File: dv/csrc_asserts.sv
`timescale 1ns/10ps
module csrc_asserts (
    input wire logic        sys_clk,
    input wire logic        rst_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        mem_start,
    input wire logic        mem_write,
    input wire logic [31:0] mem_addr,
    input wire logic        mem_claim,
    input wire logic        rom_select_n,
    input wire logic        dram_select,
    input wire logic        dram_write_en,
    input wire logic        write_drop,
    input wire logic        isa_forward,
    input wire logic        refresh_tick,
    input wire logic        refresh_req,
    input wire logic        refresh_busy,
    input wire logic        hold_req,
    input wire logic        kbd_a20_gate,
    input wire logic        addr20_mask_n
);
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);
    sequence s_setup_access;
        psel && !penable ##1 psel && penable;
    endsequence
    AST_APB_WAIT: assert property (s_setup_access |-> !pready ##1 pready)
        else $error("APB answer not after one wait state");
    AST_ERR_WITH_RDY: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    AST_CLAIM_DEF: assert property (mem_start && mem_addr[31:16] inside
        {16'h000d, 16'h000e, 16'h000f} |=> mem_claim)
        else $error("D/E/F cycle not claimed");
    AST_OUTSIDE_IDLE: assert property (mem_start && mem_addr[31:16] < 16'h000d |=>
        !mem_claim && rom_select_n && !dram_select && !isa_forward)
        else $error("low cycle was steered");
    AST_STEER_PULSE: assert property (!mem_start |=> !mem_claim && rom_select_n && !write_drop)
        else $error("steering output without cycle");
    AST_READ_KEEP: assert property (mem_start && !mem_write |=> !write_drop && !dram_write_en)
        else $error("read cycle treated as write");
    AST_DROP_EXCL: assert property (write_drop |-> !dram_select && !isa_forward)
        else $error("dropped write still steered");
    AST_HIDDEN: assert property (!refresh_busy |=> !hold_req)
        else $error("hold request without refresh");
    AST_A20_KBD: assert property (kbd_a20_gate |=> addr20_mask_n)
        else $error("keyboard gate did not raise A20");
    AST_REF_CAUSE: assert property (refresh_req |-> $past(refresh_tick))
        else $error("refresh request without tick");
endmodule

bind csrc_top csrc_asserts i_csrc_asserts (
    .sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pready(pready), .pslverr(pslverr), .mem_start(mem_start), .mem_write(mem_write),
    .mem_addr(mem_addr), .mem_claim(mem_claim), .rom_select_n(rom_select_n),
    .dram_select(dram_select), .dram_write_en(dram_write_en), .write_drop(write_drop),
    .isa_forward(isa_forward), .refresh_tick(refresh_tick), .refresh_req(refresh_req),
    .refresh_busy(refresh_busy), .hold_req(hold_req), .kbd_a20_gate(kbd_a20_gate),
    .addr20_mask_n(addr20_mask_n)
);

// File: dv/cache_shadow_refresh_config_tb.sv
`timescale 1ns/10ps
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin error_cnt++; \
    $display("Error %s exp %h got %h", n, e, a); end end
module cache_shadow_refresh_config_tb;
    logic        sys_clk, rst_n, psel, penable, pwrite, pready, pslverr, err, fl;
    logic        mem_start, mem_write, mem_claim, rom_select_n, dram_select, dram_write_en;
    logic        write_drop, isa_forward, refresh_tick, refresh_busy, refresh_req, hold_req;
    logic        kbd_a20_gate, addr20_mask_n, byte_swap_en, parity_check_en, l2_enable;
    logic [1:0]  l2_wr_leadoff, l2_rd_leadoff;
    logic [3:0]  l2_size_sel;
    logic [10:0] cfg_out;
    logic [5:0]  steer_out;
    logic [7:0]  c, sh, sg;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, mem_addr, st, rd;
    int          error_cnt, num_checks, cyc;

    csrc_top i_csrc_top (
        .sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .mem_start(mem_start), .mem_write(mem_write), .mem_addr(mem_addr),
        .mem_claim(mem_claim), .rom_select_n(rom_select_n), .dram_select(dram_select),
        .dram_write_en(dram_write_en), .write_drop(write_drop), .isa_forward(isa_forward),
        .refresh_tick(refresh_tick), .refresh_busy(refresh_busy), .refresh_req(refresh_req),
        .hold_req(hold_req), .kbd_a20_gate(kbd_a20_gate), .addr20_mask_n(addr20_mask_n),
        .byte_swap_en(byte_swap_en), .parity_check_en(parity_check_en), .l2_enable(l2_enable),
        .l2_size_sel(l2_size_sel), .l2_wr_leadoff(l2_wr_leadoff), .l2_rd_leadoff(l2_rd_leadoff)
    );

    assign cfg_out = {byte_swap_en, parity_check_en, l2_enable, l2_size_sel, l2_wr_leadoff,
                      l2_rd_leadoff};
    assign steer_out = {mem_claim, rom_select_n, dram_select, dram_write_en, write_drop,
                        isa_forward};

    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] t;
        t = v ^ (v << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction

    task automatic nx;
        st = xs(st);
    endtask

    function automatic logic [10:0] cfg(input logic [7:0] v);
        return {v[7], ~v[5], v[4], 4'h1 << v[3:2], v[1] ? 2'h2 : 2'h3, v[0] ? 2'h2 : 2'h3};
    endfunction

    function automatic logic [5:0] exp_mem(input logic w, input logic [31:0] a);
        logic e;
        logic b;
        logic p;
        e = a[31:16] == 16'h000e;
        b = sg[{e, a[15:14]}];
        p = e ? sh[3] : sh[4];
        if (a[31:16] == 16'h000f)
            return sh[7] ? (w ? {1'b1, ~fl, 4'b1100} : 6'b100000) : (w ? 6'b110010 : 6'b111000);
        if (a[31:16] != 16'h000d && !e)
            return 6'b010000;
        if (!b)
            return 6'b110001;
        return w ? (p ? 6'b110010 : 6'b111100) : 6'b111000;
    endfunction

    // The request is held until the edge that samples pready; pready is read just after
    // the previous edge, where it is settled, so no race with the design's update.
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        logic r;
        int   n;
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge sys_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            #1;
            r = pready;
            rd = prdata;
            err = pslverr;
            n++;
            @(posedge sys_clk);
        end while (!r);
        psel <= 1'b0;
        penable <= 1'b0;
        `CHK("pready_wait", 2, n)
    endtask

    task automatic rchk(input logic [11:0] a, input logic [7:0] e);
        apb(1'b0, a, 8'h00);
        `CHK("prdata", {24'h0, e}, rd)
    endtask

    task automatic mem(input logic w, input logic [31:0] a);
        @(posedge sys_clk);
        mem_start <= 1'b1;
        mem_write <= w;
        mem_addr <= a;
        @(posedge sys_clk);
        mem_start <= 1'b0;
        #1;
        `CHK("steer", exp_mem(w, a), steer_out)
    endtask

    task automatic tick(input logic e);
        @(posedge sys_clk);
        refresh_tick <= 1'b1;
        @(posedge sys_clk);
        refresh_tick <= 1'b0;
        #1;
        `CHK("refresh_req", e, refresh_req)
    endtask

    task automatic results;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            results;
        end
    end

    initial begin
        {psel, penable, pwrite, mem_start, mem_write, refresh_tick, refresh_busy} = '0;
        {paddr, pwdata, mem_addr, kbd_a20_gate, rst_n} = '0;
        st = 32'd61608;
        error_cnt = 0;
        num_checks = 0;
        repeat (3) @(posedge sys_clk);
        rst_n <= 1'b1;
        #1;
        `CHK("cfg", cfg(8'h00), cfg_out)
        rchk(12'h084, 8'h00);
        rchk(12'h088, 8'he4);
        rchk(12'h08c, 8'h00);
        rchk(12'h098, 8'h00);
        apb(1'b1, 12'h090, 8'hff);
        `CHK("pslverr", 1'b1, err)
        rchk(12'h090, 8'h00);
        for (int i = 0; i < 12; i++) begin
            nx;
            c = i < 4 ? {4'hb, i[1:0], i[1:0]} : st[7:0] & 8'hbf;
            apb(1'b1, 12'h084, c);
            @(posedge sys_clk);
            #1;
            `CHK("cfg", cfg(c), cfg_out)
            rchk(12'h084, c);
        end
        for (int i = 0; i < 48; i++) begin
            if (i % 8 == 0) begin
                nx;
                sh = {i[3], 2'b11, st[4:1], 1'b0};
                sg = st[15:8];
                fl = st[16];
                apb(1'b1, 12'h088, sh);
                apb(1'b1, 12'h08c, sg);
                apb(1'b1, 12'h098, {fl, 7'h0});
                rchk(12'h08c, sg);
            end
            nx;
            mem(st[0], {12'h000, 2'b11, st[2:1], st[31:16]});
        end
        apb(1'b1, 12'h088, 8'he4);
        tick(1'b1);
        // Slow mode only with DRAMs that tolerate it; here the counter starts cleared.
        apb(1'b1, 12'h088, 8'he5);
        for (int i = 1; i <= 8; i++)
            tick(i % 4 == 0);
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, 12'h088, {5'b11100, i[0], i[1], 1'b0});
            @(posedge sys_clk);
            refresh_busy <= 1'b1;
            @(posedge sys_clk);
            refresh_busy <= 1'b0;
            kbd_a20_gate <= 1'b1;
            #1;
            `CHK("hold_req", i[0], hold_req)
            `CHK("addr20_mask_n", i[1], addr20_mask_n)
            @(posedge sys_clk);
            kbd_a20_gate <= 1'b0;
            #1;
            `CHK("hold_req", 1'b0, hold_req)
            `CHK("addr20_mask_n", 1'b1, addr20_mask_n)
        end
        // A second reset in mid-run must bring every field back to its default.
        @(posedge sys_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        #1;
        `CHK("cfg", cfg(8'h00), cfg_out)
        `CHK("addr20_mask_n", 1'b0, addr20_mask_n)
        rchk(12'h084, 8'h00);
        rchk(12'h088, 8'he4);
        rchk(12'h08c, 8'h00);
        rchk(12'h098, 8'h00);
        results;
    end
endmodule
